// >>> shared/ssp_pkg.sv
// package of the synchronous serial port: register map, fields, reset values, timing
// assumes a plain address/strobe register port and a single system clock
package ssp_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] ADDR_CTRL3 = 3'h2;
    localparam logic [2:0] ADDR_BUF = 3'h3;
    localparam logic [2:0] ADDR_BAUD = 3'h4;
    localparam logic [2:0] ADDR_FLAGS = 3'h5;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int STAT_SAMPLE_LATE = 7;
    localparam int STAT_EDGE_SEL = 6;
    localparam int STAT_BUF_FULL = 0;
    localparam int CTRL1_WRITE_COLLISION_FLAG = 7;
    localparam int CTRL1_OVERFLOW = 6;
    localparam int CTRL1_ENABLE = 5;
    localparam int CTRL1_IDLE_POL = 4;
    localparam int CTRL3_BUF_OVERWRITE = 4;
    localparam int FLAGS_DONE = 0;
    localparam int FLAGS_I2C_MODE = 1;

    // ----------------------------------------------------------------
    // mode field values (low nibble of first control register)
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_HOST_DIV4 = 4'h0;
    localparam logic [3:0] MODE_HOST_DIV16 = 4'h1;
    localparam logic [3:0] MODE_HOST_DIV64 = 4'h2;
    localparam logic [3:0] MODE_HOST_TIMER = 4'h3;
    localparam logic [3:0] MODE_CLIENT_SEL = 4'h4;
    localparam logic [3:0] MODE_CLIENT_NOSEL = 4'h5;
    localparam logic [3:0] MODE_HOST_BAUD = 4'ha;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] BITS_LAST = 3'h7;
    localparam logic [7:0] DIV4_HALF = 8'h02;
    localparam logic [7:0] DIV16_HALF = 8'h08;
    localparam logic [7:0] DIV64_HALF = 8'h20;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ssp_req_s;

    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_LEAD = 2'b01,
        SSP_TRAIL = 2'b11
    } ssp_phase_e;

endpackage

// >>> logic/ssp_sync2.sv
// two-flop synchroniser for one pin input
// assumes the input is asynchronous to clk_i
module ssp_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule // ssp_sync2

// >>> logic/ssp_port.sv
// spi host/client shifter of the synchronous serial port with its registers
// assumes one system clock; client clock, select and data pins arrive asynchronously
//
// Overview of operation
// - eight-bit shift register, msb out, lsb in
// - change on one edge, capture on opposite
// - each clock sends and receives one bit
// - deselected client ignores clock, drives nothing
// - full byte copied to buffer, done flag
// - buffer write loads buffer and shifter together
// - shifter reachable only through the buffer
// - status low six read-only, top two writable
// - first control register fully read/write
// - baud reload value sets host clock rate
// - port is either spi or i2c, exclusively
// - host rate div 4, 16, 64, timer, baud
// - write during transfer dropped, collision flag set
// - buffer full set on byte received, cleared on read
// - select high releases data output mid-byte
//
// Added by the designer: the address-and-strobe port and the register offsets.
module ssp_port #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ssp_pkg::ssp_req_s req_i,
    output logic [7:0] rdata_o,
    input wire logic timer_tick_i,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    input wire logic sel_n_i,
    output logic done_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] stat_top_q;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl3_q;
    logic [7:0] buf_q;
    logic [7:0] baud_q;
    logic i2c_mode_q;
    logic buf_full_q;
    logic done_q;
    logic write_collision_flag_q;
    logic ovf_q;
    logic [WIDTH-1:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic sdo_q;
    logic sck_q;
    logic [7:0] div_cnt_q;
    logic [7:0] rdata_q;
    ssp_pkg::ssp_phase_e phase_q;

    logic sck_s;
    logic sdi_s;
    logic sel_n_s;
    logic sck_prev_q;

    ssp_sync2 #(.RST_VAL(1'b0)) u_sync_sck (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sck_i),
        .q_o(sck_s)
    );
    ssp_sync2 #(.RST_VAL(1'b0)) u_sync_sdi (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sdi_i),
        .q_o(sdi_s)
    );
    ssp_sync2 #(.RST_VAL(1'b1)) u_sync_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sel_n_i),
        .q_o(sel_n_s)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [3:0] mode;
    logic enabled;
    logic is_client;
    logic sel_ctrl;
    logic selected;
    logic busy;
    logic buf_wr;
    logic buf_rd;
    logic wr_ok;
    logic idle_pol;
    logic edge_sel;
    logic [7:0] half_period;

    assign mode = ctrl1_q[3:0];
    assign idle_pol = ctrl1_q[ssp_pkg::CTRL1_IDLE_POL];
    assign edge_sel = stat_top_q[ssp_pkg::STAT_EDGE_SEL - 6];
    assign enabled = ctrl1_q[ssp_pkg::CTRL1_ENABLE] && !i2c_mode_q;
    assign is_client = (mode == ssp_pkg::MODE_CLIENT_SEL) || (mode == ssp_pkg::MODE_CLIENT_NOSEL);
    assign sel_ctrl = mode == ssp_pkg::MODE_CLIENT_SEL;
    assign selected = !sel_ctrl || !sel_n_s;
    assign busy = enabled && ((phase_q != ssp_pkg::SSP_IDLE) || (is_client && bit_cnt_q != 3'h0));
    assign buf_wr = req_i.wr && req_i.addr == ssp_pkg::ADDR_BUF;
    assign buf_rd = req_i.rd && req_i.addr == ssp_pkg::ADDR_BUF;
    assign wr_ok = buf_wr && !busy && !write_collision_flag_q;

    always_comb begin
        unique case (mode)
            ssp_pkg::MODE_HOST_DIV16: half_period = ssp_pkg::DIV16_HALF;
            ssp_pkg::MODE_HOST_DIV64: half_period = ssp_pkg::DIV64_HALF;
            ssp_pkg::MODE_HOST_BAUD: half_period = 8'((baud_q + 8'h01) << 1);
            default: half_period = ssp_pkg::DIV4_HALF;
        endcase
    end

    // ------------------------------------------------------------
    // serial clock edges: client lead edge shifts out, trail edge captures
    // ------------------------------------------------------------
    logic host_tick;
    logic lead_edge;
    logic trail_edge;
    logic c_rise;
    logic c_fall;
    logic c_lead;
    logic c_trail;

    assign host_tick = (mode == ssp_pkg::MODE_HOST_TIMER) ? timer_tick_i : (div_cnt_q == 8'h01);
    assign c_rise = sck_s && !sck_prev_q;
    assign c_fall = !sck_s && sck_prev_q;
    // active edge toward idle when edge select set, away from idle otherwise
    assign c_lead = (edge_sel ^ idle_pol) ? c_fall : c_rise;
    assign c_trail = (edge_sel ^ idle_pol) ? c_rise : c_fall;
    // client only: host moves its data on the trail tick
    assign lead_edge = is_client && enabled && selected && c_lead;
    assign trail_edge = is_client ? (enabled && selected && c_trail)
                                  : (enabled && phase_q == ssp_pkg::SSP_TRAIL && host_tick);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
        end
    end

    // ------------------------------------------------------------
    // host clock generator
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_q <= ssp_pkg::RST_BYTE;
        end else if (!enabled || is_client || phase_q == ssp_pkg::SSP_IDLE || host_tick) begin
            div_cnt_q <= half_period;
        end else if (div_cnt_q != 8'h00) begin
            div_cnt_q <= div_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= ssp_pkg::SSP_IDLE;
        end else if (!enabled || is_client) begin
            phase_q <= ssp_pkg::SSP_IDLE;
        end else begin
            unique case (phase_q)
                ssp_pkg::SSP_IDLE: if (wr_ok) phase_q <= ssp_pkg::SSP_LEAD;
                ssp_pkg::SSP_LEAD: if (host_tick) phase_q <= ssp_pkg::SSP_TRAIL;
                ssp_pkg::SSP_TRAIL: if (host_tick) begin
                    phase_q <= (bit_cnt_q == ssp_pkg::BITS_LAST) ? ssp_pkg::SSP_IDLE : ssp_pkg::SSP_LEAD;
                end
                default: phase_q <= ssp_pkg::SSP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_q <= 1'b0;
        end else if (phase_q == ssp_pkg::SSP_IDLE || !enabled) begin
            sck_q <= idle_pol;
        end else if (host_tick) begin
            sck_q <= !sck_q;
        end
    end

    // ------------------------------------------------------------
    // shifter and bit counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= WIDTH'(0);
        end else if (wr_ok) begin
            shift_q <= WIDTH'(req_i.wdata);
        end else if (trail_edge) begin
            // synchroniser delay puts the pin sample just after the opposite edge
            shift_q <= {shift_q[WIDTH-2:0], sdi_s};
        end
        // untouched shifter keeps its byte as next dummy data
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_cnt_q <= 3'h0;
        end else if (!enabled || (sel_ctrl && sel_n_s)) begin
            bit_cnt_q <= 3'h0; // select high resets a partial byte
        end else if (trail_edge) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdo_q <= 1'b0;
        end else if (wr_ok) begin
            sdo_q <= req_i.wdata[7];
        end else if (trail_edge && !is_client) begin
            sdo_q <= shift_q[WIDTH-2];
        end else if (lead_edge) begin
            sdo_q <= shift_q[WIDTH-1];
        end else if (is_client && bit_cnt_q == 3'h0 && !busy) begin
            sdo_q <= shift_q[WIDTH-1];
        end
    end

    // ------------------------------------------------------------
    // buffer, flags and completion
    // ------------------------------------------------------------
    logic byte_done;
    assign byte_done = trail_edge && bit_cnt_q == ssp_pkg::BITS_LAST;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_q <= ssp_pkg::RST_BYTE;
        end else if (byte_done) begin
            buf_q <= 8'({shift_q[WIDTH-2:0], sdi_s});
        end else if (wr_ok) begin
            buf_q <= req_i.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_full_q <= 1'b0;
        end else if (byte_done) begin
            buf_full_q <= 1'b1;
        end else if (buf_rd) begin
            buf_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
        end else if (byte_done && buf_full_q && !ctrl3_q[ssp_pkg::CTRL3_BUF_OVERWRITE]) begin
            ovf_q <= 1'b1;
        end else if (req_i.wr && req_i.addr == ssp_pkg::ADDR_CTRL1) begin
            ovf_q <= req_i.wdata[ssp_pkg::CTRL1_OVERFLOW];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_collision_flag_q <= 1'b0;
        end else if (buf_wr && busy) begin
            write_collision_flag_q <= 1'b1;
        end else if (req_i.wr && req_i.addr == ssp_pkg::ADDR_CTRL1) begin
            write_collision_flag_q <= req_i.wdata[ssp_pkg::CTRL1_WRITE_COLLISION_FLAG];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else if (byte_done) begin
            done_q <= 1'b1;
        end else if (req_i.wr && req_i.addr == ssp_pkg::ADDR_FLAGS) begin
            done_q <= req_i.wdata[ssp_pkg::FLAGS_DONE];
        end
    end

    // ------------------------------------------------------------
    // software writable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_q <= ssp_pkg::RST_BYTE;
            stat_top_q <= 2'h0;
            ctrl3_q <= ssp_pkg::RST_BYTE;
            baud_q <= ssp_pkg::RST_BYTE;
            i2c_mode_q <= 1'b0;
        end else if (req_i.wr) begin
            unique case (req_i.addr)
                ssp_pkg::ADDR_CTRL1: ctrl1_q <= req_i.wdata;
                ssp_pkg::ADDR_STATUS: stat_top_q <= req_i.wdata[7:6];
                ssp_pkg::ADDR_CTRL3: ctrl3_q <= req_i.wdata;
                ssp_pkg::ADDR_BAUD: baud_q <= req_i.wdata;
                ssp_pkg::ADDR_FLAGS: i2c_mode_q <= req_i.wdata[ssp_pkg::FLAGS_I2C_MODE];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= ssp_pkg::RST_BYTE;
        end else if (req_i.rd) begin
            unique case (req_i.addr)
                ssp_pkg::ADDR_STATUS: rdata_q <= {stat_top_q, 5'h00, buf_full_q};
                ssp_pkg::ADDR_CTRL1: rdata_q <= {write_collision_flag_q, ovf_q, ctrl1_q[5:0]};
                ssp_pkg::ADDR_CTRL3: rdata_q <= ctrl3_q;
                ssp_pkg::ADDR_BUF: rdata_q <= buf_q;
                ssp_pkg::ADDR_BAUD: rdata_q <= baud_q;
                ssp_pkg::ADDR_FLAGS: rdata_q <= {6'h00, i2c_mode_q, done_q};
                default: rdata_q <= ssp_pkg::RST_BYTE;
            endcase
        end else begin
            rdata_q <= ssp_pkg::RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata_o = rdata_q;
    assign done_o = done_q;
    assign sck_o = sck_q;
    assign sck_oe_n_o = !(enabled && !is_client);
    assign sdo_o = sdo_q;
    assign sdo_oe_n_o = !(enabled && (!is_client || !sel_ctrl || !sel_n_s));
endmodule // ssp_port

// >>> tb/ssp_port_props.sv
// checker of the serial port pins and register answers
// assumes binding onto ssp_port, one clock, synchronous reset
module ssp_port_props #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ssp_pkg::ssp_req_s req_i,
    input wire logic [7:0] rdata_o,
    input wire logic timer_tick_i,
    input wire logic sck_i,
    input wire logic sck_o,
    input wire logic sck_oe_n_o,
    input wire logic sdi_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_n_o,
    input wire logic sel_n_i,
    input wire logic done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    chk_rdata_quiet: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_unmapped_zero: assert property ($past(req_i.rd) && $past(req_i.addr) > ssp_pkg::ADDR_FLAGS
        |-> rdata_o == 8'h00)
        else $error("unmapped read returned data");
    chk_sck_still: assert property (sck_oe_n_o && $past(sck_oe_n_o) |-> $stable(sck_o))
        else $error("serial clock moved while not driven");
    chk_half_min: assert property (!sck_oe_n_o && $changed(sck_o) |=> $stable(sck_o))
        else $error("serial clock half period below two cycles");
    chk_host_drives: assert property (!sck_oe_n_o |-> !sdo_oe_n_o)
        else $error("host not driving data out");
    chk_done_sticky: assert property (done_o && !(req_i.wr && req_i.addr == ssp_pkg::ADDR_FLAGS) |=> done_o)
        else $error("done flag dropped without a clear");
    chk_sdo_release: assert property ((sck_oe_n_o && sel_n_i) [*4] |-> sdo_oe_n_o)
        else $error("data out driven while deselected");
    chk_client_quiet: assert property ((sck_oe_n_o && sel_n_i && !done_o) [*5] |=> !done_o)
        else $error("deselected client completed a byte");
    cov_host_done: cover property ($rose(done_o) && !sck_oe_n_o);
    cov_client_done: cover property ($rose(done_o) && sck_oe_n_o);
    cov_release: cover property ($rose(sdo_oe_n_o) && sck_oe_n_o);
endmodule // ssp_port_props

bind ssp_port ssp_port_props #(.WIDTH(WIDTH)) i_props (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .rdata_o(rdata_o), .timer_tick_i(timer_tick_i), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
    .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .sel_n_i(sel_n_i), .done_o(done_o));

// >>> tb/ssp_peer.sv
// client model facing the port while the port is host
// assumes idle clock low, capture on leading edge, select from the bench
module ssp_peer (
    input wire logic sck_i,
    input wire logic sel_n_i,
    input wire logic mosi_i,
    input wire logic [7:0] load_i,
    output logic miso_o,
    output logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_q;
    logic bit_q;
    logic last_q;
    initial begin
        sh_q = 8'h00;
        bit_q = 1'b0;
        last_q = 1'b0;
    end
    always @(negedge sel_n_i) sh_q = load_i;
    always @(posedge sel_n_i) last_q = sh_q[7];
    always @(posedge sck_i) begin // capture on the leading edge
        if (!sel_n_i) bit_q = mosi_i;
    end
    always @(negedge sck_i) begin // msb out, new bit into lsb
        if (!sel_n_i) sh_q = {sh_q[6:0], bit_q};
    end
    assign miso_o = sel_n_i ? ~last_q : sh_q[7]; // nothing valid while deselected
    assign rx_o = sh_q;
endmodule // ssp_peer

// >>> tb/ssp_port_tb_top.sv
// bench of the serial port: registers, host exchanges, client exchanges
// assumes ssp_port, ssp_peer and the bound checker
module ssp_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, tick, sck, sdi_tb, sel_n, psel_n, sdi, pmiso;
    logic sck_o, sck_oe_n, sdo, sdo_oe_n, done;
    logic [7:0] rdata, prx, pload;
    ssp_pkg::ssp_req_s req;
    int checks = 0, miscompares = 0, cyc = 0, rises = 0;
    assign sdi = sck_oe_n ? sdi_tb : pmiso;
    ssp_port i_dut (.clk_i(clk), .rst_i(rst), .req_i(req), .rdata_o(rdata), .timer_tick_i(tick), .sck_i(sck),
        .sck_o(sck_o), .sck_oe_n_o(sck_oe_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .sel_n_i(sel_n),
        .done_o(done));
    ssp_peer i_peer (.sck_i(sck_o), .sel_n_i(psel_n), .mosi_i(sdo), .load_i(pload), .miso_o(pmiso), .rx_o(prx));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 3 == 2);
    end
    always @(posedge sck_o) rises++;
    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] w, input logic [7:0] e, input string n);
        logic [7:0] d;
        wr(a, w);
        rd(a, d);
        chk(n, d, e);
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] d;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            chk("reset value", d, ssp_pkg::RST_BYTE);
        end
        wr_rd(ssp_pkg::ADDR_CTRL1, 8'hc3, 8'hc3, "ctrl1");
        wr_rd(ssp_pkg::ADDR_STATUS, 8'hff, 8'hc0, "status");
        wr_rd(3'h7, 8'hff, 8'h00, "unmapped");
        wr_rd(ssp_pkg::ADDR_BAUD, 8'h01, 8'h01, "baud");
        wr_rd(ssp_pkg::ADDR_STATUS, 8'h40, 8'h40, "edge select");
        wr_rd(ssp_pkg::ADDR_FLAGS, 8'h02, 8'h02, "i2c select");
        wr(ssp_pkg::ADDR_CTRL1, 8'h20);
        wr(ssp_pkg::ADDR_BUF, 8'ha5);
        repeat (40) @(negedge clk);
        chk("spi off", {7'h00, done}, 8'h00);
        wr(ssp_pkg::ADDR_CTRL1, 8'h00);
        wr(ssp_pkg::ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_host();
        logic [3:0] md[5] = '{ssp_pkg::MODE_HOST_DIV4, ssp_pkg::MODE_HOST_DIV16, ssp_pkg::MODE_HOST_DIV64,
            ssp_pkg::MODE_HOST_TIMER, ssp_pkg::MODE_HOST_BAUD};
        logic [7:0] hf[5] = '{8'h02, 8'h08, 8'h20, 8'h03, 8'h04};
        logic [7:0] tx[5] = '{8'ha5, 8'h3c, 8'h01, 8'h80, 8'h5a};
        logic [7:0] pv[5] = '{8'hc3, 8'h7e, 8'hfe, 8'h55, 8'h0f};
        logic [7:0] d;
        int n, t0, r0;
        for (int i = 0; i < 5; i++) begin
            wr(ssp_pkg::ADDR_FLAGS, 8'h00);
            wr(ssp_pkg::ADDR_CTRL1, {4'h2, md[i]});
            pload = pv[i];
            psel_n <= 1'b0;
            r0 = rises;
            wr(ssp_pkg::ADDR_BUF, tx[i]);
            n = 0;
            while (sck_o !== 1'b1 && n < 300) begin
                @(negedge clk);
                n++;
            end
            t0 = cyc;
            @(negedge clk);
            while (sck_o !== 1'b0 && cyc - t0 < 300) @(negedge clk);
            chk("half period", 8'(cyc - t0), hf[i]);
            if (i == 1) begin
                wr(ssp_pkg::ADDR_BUF, 8'hff);
                rd(ssp_pkg::ADDR_CTRL1, d);
                chk("collision", d, {4'ha, md[i]});
            end
            n = 0;
            while (done !== 1'b1 && n < 600) begin
                @(negedge clk);
                n++;
            end
            chk("done", {7'h00, done}, 8'h01);
            repeat (70) @(negedge clk);
            @(posedge clk);
            psel_n <= 1'b1;
            chk("edges", 8'(rises - r0), 8'h08);
            chk("peer byte", prx, tx[i]);
            rd(ssp_pkg::ADDR_STATUS, d);
            chk("full set", d, 8'h41);
            rd(ssp_pkg::ADDR_BUF, d);
            chk("rx byte", d, pv[i]);
            rd(ssp_pkg::ADDR_STATUS, d);
            chk("full clear", d, 8'h40);
        end
    endtask
    task automatic cbyte(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nb; i++) begin
            sdi_tb <= tx[7 - i]; // msb first, ahead of the leading edge
            repeat (6) @(posedge clk);
            @(negedge clk);
            rx = {rx[6:0], sdo};
            @(posedge clk);
            sck <= 1'b1; // leading edge
            repeat (6) @(posedge clk);
            sck <= 1'b0;
        end
    endtask
    task automatic t_client();
        logic [7:0] d;
        wr(ssp_pkg::ADDR_CTRL1, {4'h2, ssp_pkg::MODE_CLIENT_SEL});
        wr(ssp_pkg::ADDR_FLAGS, 8'h00);
        wr(ssp_pkg::ADDR_BUF, 8'h96);
        sel_n <= 1'b0; // single client selected
        cbyte(8'h5b, 8, d); // eight pulses per group
        chk("client out", d, 8'h96);
        repeat (8) @(negedge clk);
        chk("client done", {7'h00, done}, 8'h01);
        rd(ssp_pkg::ADDR_BUF, d);
        chk("client rx", d, 8'h5b);
        cbyte(8'hc6, 8, d);
        chk("dummy out", d, 8'h5b);
        rd(ssp_pkg::ADDR_BUF, d);
        chk("second rx", d, 8'hc6);
        cbyte(8'hff, 3, d);
        @(posedge clk);
        sel_n <= 1'b1;
        repeat (6) @(negedge clk);
        chk("released", {7'h00, sdo_oe_n}, 8'h01);
        wr(ssp_pkg::ADDR_FLAGS, 8'h00);
        cbyte(8'h3c, 8, d);
        repeat (8) @(negedge clk);
        chk("ignored", {7'h00, done}, 8'h00);
        @(posedge clk);
        sel_n <= 1'b0;
        cbyte(8'h81, 8, d);
        repeat (8) @(negedge clk);
        rd(ssp_pkg::ADDR_BUF, d);
        chk("resync rx", d, 8'h81);
    endtask
    initial begin
        req = '0;
        {rst, sck, sdi_tb, sel_n, psel_n} = 5'b10011;
        pload = 8'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_host();
        t_client();
        results();
    end
    initial begin
        #(20000 * 100); // far beyond the expected run of a few thousand cycles
        miscompares++;
        results();
    end
endmodule // ssp_port_tb_top
